// File: tb/dosbm_chk.sv
// port-level assertions for the sync and button block
// bound into dosbm_top; straps take effect one edge after they change
`timescale 1ns/1ps
`default_nettype none
module dosbm_chk (
   input wire logic       i_clk,                 // clock
   input wire logic       i_resetn,              // reset
   input wire logic       i_mode_strap_a,        // strap
   input wire logic       i_mode_strap_b,        // strap
   input wire logic       i_mode_strap_c,        // strap
   input wire logic       i_mode_strap_d,        // strap
   input wire logic [1:0] i_sync_select_strap_a, // strap
   input wire logic [1:0] i_sync_select_strap_b, // strap
   input wire logic [1:0] i_output_format_strap, // strap
   input wire logic       i_wclk_present,        // sync
   input wire logic [1:0] i_wclk_rate,           // sync
   input wire logic       i_aes_present,         // sync
   input wire logic       i_spdif_present,       // sync
   input wire logic [1:0] o_sync_mode,           // out
   input wire logic       o_use_sync,            // out
   input wire logic [1:0] o_sync_source,         // out
   input wire logic [1:0] o_rate,                // out
   input wire logic       o_mute,                // out
   input wire logic       o_spdif_out,           // out
   input wire logic       o_lock_led,            // out
   input wire logic       o_setup,               // out
   input wire logic [1:0] o_programme_mode,      // out
   input wire logic [1:0] o_audition_mode,       // out
   input wire logic       o_mono_audition        // out
);
   wire [3:0] code;
   wire       no_sync;
   assign code = {i_mode_strap_d, i_mode_strap_c, i_mode_strap_b, i_mode_strap_a};
   assign no_sync = !i_wclk_present && !i_aes_present && !i_spdif_present;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   AST_MASTER: assert property (
      code == 4'h0 |=> o_sync_mode == 2'h0 && o_rate == 2'h0 && !o_use_sync)
      else $error("master decode wrong");
   AST_AUTO_WCLK: assert property (
      (code == 4'h6 || code == 4'h8) && i_wclk_present |=>
      o_use_sync && o_sync_source == 2'h1 && o_rate == $past(i_wclk_rate))
      else $error("auto not on word clock");
   AST_AUTO_INT: assert property (
      code == 4'hB && no_sync |=> !o_use_sync && o_rate == 2'h3)
      else $error("auto fallback wrong");
   AST_SLAVE_MUTE: assert property (
      code == 4'hD && no_sync |=> o_mute)
      else $error("slave not muted");
   AST_FORMAT: assert property (
      1'b1 |=> o_spdif_out == ($past(i_output_format_strap) == 2'h2))
      else $error("output format wrong");
   AST_NO_DIGITAL: assert property (
      i_sync_select_strap_a == 2'h0 && i_sync_select_strap_b == 2'h0 |=> !o_sync_source[1])
      else $error("digital sync without straps");
   AST_WRAP: assert property (
      !$stable(o_programme_mode) |-> o_programme_mode ==
      ($past(o_programme_mode) == 2'h3 ? 2'h1 : $past(o_programme_mode) + 2'h1))
      else $error("mode step wrong");
   AST_MONO_AUD: assert property (
      !o_setup && $stable(o_setup) && $stable(o_audition_mode) && o_audition_mode[1] |->
      o_mono_audition == !o_audition_mode[0])
      else $error("audition forcing wrong");
   AST_LAMP: assert property (
      code == 4'h0 [*3] |=> o_lock_led)
      else $error("lamp not steady");
endmodule // dosbm_chk
bind dosbm_top dosbm_chk u_chk (.*);
`default_nettype wire

// File: tb/dosbm_sync_src.sv
// behavioural model of the word clock and two digital sync sources
// presence rises DLY+1 edges after enable; idle rate lines keep changing
`timescale 1ns/1ps
`default_nettype none
module dosbm_sync_src #(
   parameter int DLY = 3
) (
   input  wire logic       i_clk,     // system clock
   input  wire logic [2:0] i_on,      // wclk, aes, spdif enables
   input  wire logic [1:0] i_rate,    // rate sent when present
   output var  logic [2:0] o_present, // sync detected per source
   output var  logic [5:0] o_rate     // measured rate per source
);
   int cnt_q [3] = '{0, 0, 0};
   initial
   begin
      o_present = 3'h0;
      o_rate = 6'h0;
   end
   always @(posedge i_clk)
   begin
      for (int k = 0; k < 3; k++)
      begin
         cnt_q[k] <= i_on[k] ? cnt_q[k] + 1 : 0;
         o_present[k] <= i_on[k] && cnt_q[k] >= DLY;
         // a source that has gone must not look like its last rate
         o_rate[2*k +: 2] <= (i_on[k] && cnt_q[k] >= DLY) ? i_rate : ~o_rate[2*k +: 2];
      end
   end
endmodule // dosbm_sync_src
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the sync and button block
// the sync source model plays the far side; hold times are shortened
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int ST = 12;
   logic       i_clk                  = 1'b0;
   logic       i_resetn               = 1'b0;
   logic       i_mode_strap_a         = 1'b0;
   logic       i_mode_strap_b         = 1'b0;
   logic       i_mode_strap_c         = 1'b0;
   logic       i_mode_strap_d         = 1'b0;
   logic       i_channel_status_strap = 1'b0;
   logic [1:0] i_sync_select_strap_a  = 2'h1;
   logic [1:0] i_sync_select_strap_b  = 2'h1;
   logic [1:0] i_output_format_strap  = 2'h1;
   logic       i_programme_bus_button = 1'b0;
   logic       i_audition_bus_button  = 1'b0;
   logic [2:0] src_on                 = 3'h0;
   logic [1:0] src_rate               = 2'h0;
   int         mismatches             = 0;
   int         check_count            = 0;
   wire [1:0] o_sync_mode, o_sync_source, o_rate, o_programme_mode, o_audition_mode;
   wire       o_use_sync, o_mute, o_professional, o_spdif_out, o_lock_led, o_setup;
   wire       o_programme_led, o_audition_led, o_mono_programme, o_mono_audition;
   wire       i_wclk_present, i_aes_present, i_spdif_present;
   wire [1:0] i_wclk_rate, i_aes_rate, i_spdif_rate;
   always #2 i_clk = ~i_clk;
   dosbm_top #(
      .ENTER_CYC(32'hC8),
      .EXIT_CYC (32'h50),
      .FLASH_CYC(32'hA),
      .BLINK_CYC(32'hA),
      .DEB_CYC  (12'h004)
   ) dut (.*);
   dosbm_sync_src src (
      .i_clk    (i_clk),
      .i_on     (src_on),
      .i_rate   (src_rate),
      .o_present({i_spdif_present, i_aes_present, i_wclk_present}),
      .o_rate   ({i_spdif_rate, i_aes_rate, i_wclk_rate})
   );
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   task automatic do_reset;
      @(posedge i_clk);
      i_resetn <= 1'b0;
      // sources go quiet so no sync is seen before the first scenario asks for it
      src_on <= 3'h0;
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      settle(2);
   endtask
   task automatic cfg(input logic [3:0] m, input logic [1:0] s, input logic [2:0] on,
                      input logic [1:0] r);
      @(posedge i_clk);
      {i_mode_strap_d, i_mode_strap_c, i_mode_strap_b, i_mode_strap_a} <= m;
      i_sync_select_strap_a <= s;
      i_sync_select_strap_b <= s;
      src_on <= on;
      src_rate <= r;
      settle(ST);
   endtask
   task automatic push(input logic p, input logic a, input int n);
      @(posedge i_clk);
      i_programme_bus_button <= p;
      i_audition_bus_button <= a;
      repeat (n) @(posedge i_clk);
      i_programme_bus_button <= 1'b0;
      i_audition_bus_button <= 1'b0;
      settle(ST);
   endtask
   // counts rises and changes of a lamp over w cycles
   task automatic watch(input int s, input int w, output int rises, output int flips);
      logic now;
      logic prev;
      rises = 0;
      flips = 0;
      prev = s == 0 ? o_lock_led : s == 1 ? o_programme_led : o_audition_led;
      repeat (w)
      begin
         @(negedge i_clk);
         now = s == 0 ? o_lock_led : s == 1 ? o_programme_led : o_audition_led;
         rises += int'(now && !prev);
         flips += int'(now != prev);
         prev = now;
      end
   endtask
   task automatic t_straps;
      logic [3:0] code [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB};
      int r;
      int f;
      for (int k = 0; k < 8; k++)
      begin
         cfg(code[k], 2'h1, k < 4 ? 3'h7 : 3'h0, 2'h3);
         chk("mode", o_sync_mode, k / 4);
         chk("rate", o_rate, k % 4);
         chk("use sync", o_use_sync, 0);
      end
      // unlisted strap code falls back to master 32 kHz with a blinking lamp
      cfg(4'hF, 2'h1, 3'h0, 2'h3);
      chk("reserved", {o_sync_mode, o_rate}, 0);
      watch(0, 40, r, f);
      chk("reserved lamp", f, 4);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge i_clk);
         i_channel_status_strap <= k[0];
         i_output_format_strap <= k[0] ? 2'h2 : 2'h1;
         settle(2);
         chk("status", o_professional, k);
         chk("format", o_spdif_out, k);
      end
   endtask
   task automatic t_sync;
      int r;
      int f;
      cfg(4'h8, 2'h1, 3'h3, 2'h1);
      chk("wclk first", {o_use_sync, o_sync_source, o_rate}, 5'h15);
      watch(0, 40, r, f);
      chk("steady lamp", {o_lock_led, f[3:0]}, 5'h10);
      cfg(4'hD, 2'h1, 3'h0, 2'h0);
      chk("slave mute", o_mute, 1);
      cfg(4'hD, 2'h1, 3'h1, 2'h2);
      chk("slave run", {o_mute, o_use_sync, o_rate}, 4'h6);
      do_reset;
      cfg(4'hC, 2'h1, 3'h0, 2'h2);
      chk("never seen", {o_use_sync, o_rate}, 3'h0);
      cfg(4'hC, 2'h1, 3'h2, 2'h3);
      chk("aes lock", {o_use_sync, o_sync_source, o_rate}, 5'h1B);
      cfg(4'hC, 2'h1, 3'h0, 2'h3);
      chk("held rate", {o_use_sync, o_rate}, 3'h3);
      watch(0, 40, r, f);
      chk("blink", f, 4);
      cfg(4'hC, 2'h2, 3'h6, 2'h1);
      chk("spdif lock", {o_sync_source, o_rate}, 4'hD);
      cfg(4'hC, 2'h0, 3'h6, 2'h1);
      chk("no digital", o_use_sync, 0);
   endtask
   task automatic t_buttons;
      logic [1:0] step [5] = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
      int r;
      int f;
      push(1'b0, 1'b1, 2);
      chk("glitch", o_mono_audition, 0);
      push(1'b0, 1'b1, ST);
      chk("pick aud", {o_mono_programme, o_mono_audition}, 1);
      push(1'b1, 1'b0, ST);
      chk("pick pgm", {o_mono_programme, o_mono_audition}, 2);
      push(1'b1, 1'b1, 150);
      chk("early", o_setup, 0);
      push(1'b1, 1'b1, 230);
      chk("enter", o_setup, 1);
      watch(1, 100, r, f);
      chk("flash one", r, 1);
      for (int k = 0; k < 5; k++)
      begin
         push(1'b1, 1'b0, ST);
         chk("pgm mode", o_programme_mode, step[k]);
      end
      push(1'b0, 1'b1, ST);
      watch(2, 100, r, f);
      chk("flash two", r, 2);
      push(1'b1, 1'b1, 100);
      chk("exit", o_setup, 0);
      push(1'b1, 1'b0, ST);
      chk("forced", {o_mono_programme, o_mono_audition}, 1);
      push(1'b1, 1'b1, 230);
      push(1'b1, 1'b0, ST);
      push(1'b1, 1'b0, ST);
      push(1'b1, 1'b1, 100);
      chk("mix", {o_mono_programme, o_mono_audition}, 3);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      do_reset;
      t_straps;
      t_buttons;
      t_sync;
      final_report;
   end
endmodule // tb
`default_nettype wire

// File: verilog/dosbm_debounce.v
// button debouncer: output changes only after the input is stable
// assumes inputs synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module dosbm_debounce #(
   parameter CNT_W = 12,
   parameter [CNT_W-1:0] STABLE = 12'h9C4
) (
   input  wire i_clk,    // system clock
   input  wire i_resetn, // async reset, active low
   input  wire i_raw,    // raw button level
   output reg  o_clean   // debounced level
);
   reg [CNT_W-1:0] cnt_q;
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt_q   <= {CNT_W{1'b0}};
         o_clean <= 1'b0;
      end
      else if (i_raw == o_clean)
         cnt_q <= {CNT_W{1'b0}};
      else if (cnt_q == STABLE)
      begin
         o_clean <= i_raw;
         cnt_q   <= {CNT_W{1'b0}};
      end
      else
         cnt_q <= cnt_q + 1'b1;
   end
endmodule // dosbm_debounce
`default_nettype wire

// File: verilog/dosbm_defs.vh
// constants for the digital output sync and button mode block
// assumes a 250 MHz system clock; included by bare name
`ifndef DOSBM_DEFS_VH
`define DOSBM_DEFS_VH
`define DOSBM_CLK_KHZ        250000
`define DOSBM_ENTER_HOLD_MS  5000
`define DOSBM_EXIT_HOLD_MS   2000
`define DOSBM_DEBOUNCE_US    10
`define DOSBM_FLASH_MS       200
`define DOSBM_BLINK_MS       250
// sync loss timeout in system cycles
`define DOSBM_SYNC_TO_CYC    20'h186A0
// rate codes
`define DOSBM_R32            2'h0
`define DOSBM_R441           2'h1
`define DOSBM_R48            2'h2
`define DOSBM_R96            2'h3
// sync modes
`define DOSBM_M_MASTER       2'h0
`define DOSBM_M_AUTO         2'h1
`define DOSBM_M_ALOCK        2'h2
`define DOSBM_M_SLAVE        2'h3
// button modes
`define DOSBM_BM_NORMAL      2'h1
`define DOSBM_BM_ON          2'h2
`define DOSBM_BM_OFF         2'h3
// sync source codes
`define DOSBM_SRC_NONE       2'h0
`define DOSBM_SRC_WCLK       2'h1
`define DOSBM_SRC_AES        2'h2
`define DOSBM_SRC_SPDIF      2'h3
// strap-pair positions
`define DOSBM_POS_NONE       2'h0
`define DOSBM_POS_12         2'h1
`define DOSBM_POS_23         2'h2
`endif

// File: verilog/dosbm_top.v
// sync mode, lock indicator and two-button setup logic of a digital output channel
// assumes straps and sync-present levels are synchronous to i_clk
// Functional notes
// - master mode uses internal generator at strapped rate, ignores sync.
// - auto follows sync; without sync uses internal strapped rate.
// - auto lock follows detected sync while valid sync is present.
// - auto lock on sync loss picks internal rate nearest last sync.
// - auto lock with no sync ever seen runs internal at 32 kHz.
// - slave follows sync and mutes output while sync is absent.
// - master strap codes: none 32, a 44.1, b 48, a+c 96.
// - auto codes b+c, a+b+c, d, a+b+d; c+d auto lock; a+c+d slave.
// - status strap absent gives consumer, fitted gives professional status.
// - sync straps at 1-2 pick AES/EBU, 2-3 pick S/PDIF.
// - format strap 1-2 gives AES/EBU, 2-3 gives S/PDIF output.
// - both sync straps removed disables digital sync locking.
// - lock lamp steady while locked, flashes when sync is lost.
// - search word clock then selected digital input, lock once found.
// - both buttons held 5 s enters setup; buttons flash repeatedly.
// - in setup each button flashes its mode number repeatedly.
// - setup press advances mode, wrapping past the highest to one.
// - both buttons held 2 s leaves setup.
// - programme mode: normal, always selected, never selected.
// - audition mode: normal, always selected, never selected.
// - both in always-on mode gives a mix of both buses.
// - normal operation lets buttons choose the mono source.
`timescale 1ns/1ps
`default_nettype none
`include "dosbm_defs.vh"
module dosbm_top #(
   parameter ENTER_CYC = 32'd1250000000, // 5 s hold
   parameter EXIT_CYC  = 32'd500000000,  // 2 s hold
   parameter FLASH_CYC = 32'd50000000,   // setup flash half period
   parameter BLINK_CYC = 32'd62500000,   // lost-sync blink half period
   parameter DEB_CYC   = 12'h9C4         // debounce time
) (
   input  wire       i_clk,                 // 250 MHz system clock
   input  wire       i_resetn,              // async reset, active low
   input  wire       i_mode_strap_a,        // strap fitted = 1
   input  wire       i_mode_strap_b,        // strap fitted = 1
   input  wire       i_mode_strap_c,        // strap fitted = 1
   input  wire       i_mode_strap_d,        // strap fitted = 1
   input  wire       i_channel_status_strap,// fitted = 1
   input  wire [1:0] i_sync_select_strap_a, // 0 none, 1 pins 1-2, 2 pins 2-3
   input  wire [1:0] i_sync_select_strap_b, // same coding
   input  wire [1:0] i_output_format_strap, // same coding
   input  wire       i_wclk_present,        // word clock detected
   input  wire [1:0] i_wclk_rate,           // measured word clock rate
   input  wire       i_aes_present,         // AES/EBU sync detected
   input  wire [1:0] i_aes_rate,            // measured AES/EBU rate
   input  wire       i_spdif_present,       // S/PDIF sync detected
   input  wire [1:0] i_spdif_rate,          // measured S/PDIF rate
   input  wire       i_programme_bus_button,// raw button, pressed = 1
   input  wire       i_audition_bus_button, // raw button, pressed = 1
   output reg  [1:0] o_sync_mode,           // decoded mode
   output reg        o_use_sync,            // 1 output clock follows sync
   output reg  [1:0] o_sync_source,         // chosen sync source
   output reg  [1:0] o_rate,                // active sample rate code
   output reg        o_mute,                // output muted
   output reg        o_professional,        // professional channel status
   output reg        o_spdif_out,           // 1 S/PDIF output format
   output reg        o_lock_led,            // lock indicator
   output reg        o_setup,               // setup mode active
   output reg        o_programme_led,       // programme button lamp
   output reg        o_audition_led,        // audition button lamp
   output reg  [1:0] o_programme_mode,      // programme button mode
   output reg  [1:0] o_audition_mode,       // audition button mode
   output reg        o_mono_programme,      // programme bus feeds mono
   output reg        o_mono_audition        // audition bus feeds mono
);
   // nearest available internal rate is the measured one, since codes match
   function [1:0] dosbm_next_mode;
      input [1:0] m;
      begin
         dosbm_next_mode = (m == `DOSBM_BM_OFF) ? `DOSBM_BM_NORMAL : m + 2'h1;
      end
   endfunction

   // strap decode
   reg [1:0] smode;
   reg [1:0] srate;
   reg       sreserved;
   always @*
   begin
      smode     = `DOSBM_M_MASTER;
      srate     = `DOSBM_R32;
      sreserved = 1'b0;
      // master codes, auto, auto lock and slave codes
      case ({i_mode_strap_a, i_mode_strap_b, i_mode_strap_c, i_mode_strap_d})
         4'h0: srate = `DOSBM_R32;
         4'h8: srate = `DOSBM_R441;
         4'h4: srate = `DOSBM_R48;
         4'hA: srate = `DOSBM_R96;
         4'h6: begin smode = `DOSBM_M_AUTO; srate = `DOSBM_R32; end
         4'hE: begin smode = `DOSBM_M_AUTO; srate = `DOSBM_R441; end
         4'h1: begin smode = `DOSBM_M_AUTO; srate = `DOSBM_R48; end
         4'hD: begin smode = `DOSBM_M_AUTO; srate = `DOSBM_R96; end
         4'h3: smode = `DOSBM_M_ALOCK;
         4'hB: smode = `DOSBM_M_SLAVE;
         // reserved codes fall back to master 32 kHz
         default: sreserved = 1'b1;
      endcase
   end

   // sync source search, word clock first
   reg [1:0] src;
   reg       present;
   reg [1:0] meas;
   wire      straps_agree = (i_sync_select_strap_a == i_sync_select_strap_b);
   always @*
   begin
      src     = `DOSBM_SRC_NONE;
      present = 1'b0;
      meas    = `DOSBM_R32;
      // autonomous search of word clock then digital input
      if (i_wclk_present)
      begin
         src = `DOSBM_SRC_WCLK; present = 1'b1; meas = i_wclk_rate;
      end
      // strap position picks digital input; mismatched straps pick none
      // no straps means no digital sync
      else if (straps_agree && i_sync_select_strap_a == `DOSBM_POS_12 && i_aes_present)
      begin
         src = `DOSBM_SRC_AES; present = 1'b1; meas = i_aes_rate;
      end
      else if (straps_agree && i_sync_select_strap_a == `DOSBM_POS_23 && i_spdif_present)
      begin
         src = `DOSBM_SRC_SPDIF; present = 1'b1; meas = i_spdif_rate;
      end
   end

   reg       seen_q;
   reg [1:0] last_q;
   reg [31:0] blink_cnt_q;
   reg        blink_q;
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         seen_q <= 1'b0; last_q <= `DOSBM_R32;
         blink_cnt_q <= 32'h0; blink_q <= 1'b0;
         o_sync_mode <= `DOSBM_M_MASTER; o_use_sync <= 1'b0;
         o_sync_source <= `DOSBM_SRC_NONE; o_rate <= `DOSBM_R32;
         o_mute <= 1'b1; o_professional <= 1'b0; o_spdif_out <= 1'b0;
         o_lock_led <= 1'b0;
      end
      else
      begin
         if (blink_cnt_q >= BLINK_CYC - 32'h1)
         begin
            blink_cnt_q <= 32'h0; blink_q <= ~blink_q;
         end
         else
            blink_cnt_q <= blink_cnt_q + 32'h1;
         if (present)
         begin
            seen_q <= 1'b1; last_q <= meas;
         end
         o_sync_mode   <= smode;
         o_sync_source <= (smode == `DOSBM_M_MASTER) ? `DOSBM_SRC_NONE : src;
         o_professional <= i_channel_status_strap;
         // output format; default and unfitted are AES/EBU
         o_spdif_out <= (i_output_format_strap == `DOSBM_POS_23);
         o_mute <= 1'b0;
         o_use_sync <= 1'b0;
         o_rate <= srate;
         o_lock_led <= 1'b1;
         case (smode)
            `DOSBM_M_MASTER: o_rate <= srate;
            // auto follows sync else strapped internal rate
            `DOSBM_M_AUTO:
               if (present)
               begin
                  o_use_sync <= 1'b1; o_rate <= meas;
               end
            `DOSBM_M_ALOCK:
               if (present)
               begin
                  o_use_sync <= 1'b1; o_rate <= meas;
               end
               // nearest to last sync, 32 kHz if never seen
               else
                  o_rate <= seen_q ? last_q : `DOSBM_R32;
            `DOSBM_M_SLAVE:
               if (present)
               begin
                  o_use_sync <= 1'b1; o_rate <= meas;
               end
               else
                  o_mute <= 1'b1;
            default: o_rate <= srate;
         endcase
         // steady while locked, flashing once sync is lost
         if (smode != `DOSBM_M_MASTER && !present && (seen_q || smode == `DOSBM_M_SLAVE))
            o_lock_led <= blink_q;
         if (sreserved)
            o_lock_led <= blink_q;
      end
   end

   wire pgm_db;
   wire aud_db;
   dosbm_debounce #(.CNT_W(12), .STABLE(DEB_CYC)) u_deb_pgm (
      .i_clk(i_clk), .i_resetn(i_resetn),
      .i_raw(i_programme_bus_button), .o_clean(pgm_db));
   dosbm_debounce #(.CNT_W(12), .STABLE(DEB_CYC)) u_deb_aud (
      .i_clk(i_clk), .i_resetn(i_resetn),
      .i_raw(i_audition_bus_button), .o_clean(aud_db));

   reg        pgm_prev_q;
   reg        aud_prev_q;
   reg [31:0] hold_q;
   reg        hold_done_q;   // blocks presses until both released
   reg        pgm_sel_q;
   reg [31:0] fl_cnt_q;
   reg        fl_ph_q;
   reg [2:0]  fl_idx_q;
   wire both = pgm_db & aud_db;
   wire pgm_rel = pgm_prev_q & ~pgm_db;
   wire aud_rel = aud_prev_q & ~aud_db;
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pgm_prev_q <= 1'b0; aud_prev_q <= 1'b0;
         hold_q <= 32'h0; hold_done_q <= 1'b0;
         o_setup <= 1'b0; pgm_sel_q <= 1'b1;
         o_programme_mode <= `DOSBM_BM_NORMAL; o_audition_mode <= `DOSBM_BM_NORMAL;
         fl_cnt_q <= 32'h0; fl_ph_q <= 1'b0; fl_idx_q <= 3'h0;
      end
      else
      begin
         pgm_prev_q <= pgm_db;
         aud_prev_q <= aud_db;
         // hold timed on debounced level, bounce filtered before here
         if (!both)
            hold_q <= 32'h0;
         else if (!hold_done_q)
            hold_q <= hold_q + 32'h1;
         if (!pgm_db && !aud_db)
            hold_done_q <= 1'b0;
         if (!o_setup && both && !hold_done_q && hold_q >= ENTER_CYC - 32'h1)
         begin
            o_setup <= 1'b1; hold_done_q <= 1'b1; hold_q <= 32'h0;
         end
         if (o_setup && both && !hold_done_q && hold_q >= EXIT_CYC - 32'h1)
         begin
            o_setup <= 1'b0; hold_done_q <= 1'b1; hold_q <= 32'h0;
         end
         // single presses act on release; a two-button hold that enters or leaves setup is not a press
         if (!hold_done_q && !both)
         begin
            if (o_setup)
            begin
               if (pgm_rel && !aud_db)
                  o_programme_mode <= dosbm_next_mode(o_programme_mode);
               if (aud_rel && !pgm_db)
                  o_audition_mode <= dosbm_next_mode(o_audition_mode);
            end
            else
            begin
               if (pgm_rel && !aud_db)
                  pgm_sel_q <= 1'b1;
               if (aud_rel && !pgm_db)
                  pgm_sel_q <= 1'b0;
            end
         end
         // flash frame: 5 slots, one flash per mode number then the remaining slots dark
         if (fl_cnt_q >= FLASH_CYC - 32'h1)
         begin
            fl_cnt_q <= 32'h0;
            fl_ph_q  <= ~fl_ph_q;
            if (fl_ph_q)
               fl_idx_q <= (fl_idx_q == 3'h4) ? 3'h0 : fl_idx_q + 3'h1;
         end
         else
            fl_cnt_q <= fl_cnt_q + 32'h1;
      end
   end

   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_programme_led <= 1'b0; o_audition_led <= 1'b0;
         o_mono_programme <= 1'b1; o_mono_audition <= 1'b0;
      end
      else
      begin
         o_programme_led <= o_setup ? (~fl_ph_q & ({1'b0, fl_idx_q} < {2'h0, o_programme_mode}))
                                    : o_mono_programme;
         o_audition_led  <= o_setup ? (~fl_ph_q & ({1'b0, fl_idx_q} < {2'h0, o_audition_mode}))
                                    : o_mono_audition;
         // programme mode, audition mode, both on mixes
         o_mono_programme <= (o_programme_mode == `DOSBM_BM_ON) ||
                             (o_programme_mode == `DOSBM_BM_NORMAL && pgm_sel_q &&
                              o_audition_mode != `DOSBM_BM_ON);
         o_mono_audition  <= (o_audition_mode == `DOSBM_BM_ON) ||
                             (o_audition_mode == `DOSBM_BM_NORMAL && !pgm_sel_q &&
                              o_programme_mode != `DOSBM_BM_ON);
      end
   end
endmodule // dosbm_top
`default_nettype wire
